// *** dv/stm_host_model.sv ***
/*
 Bus master model: start, stop, byte writes and one-byte reads, 400 ns halves.
 Assumes the bench resolves the open-drain data line with a pull-up.
*/
`timescale 1ns/100ps

module stm_host_model (
    // Pacing clock
    input wire logic ref_clk,
    // Bus
    input wire logic bus_data,
    output logic bus_clock,
    output logic data_pull_low
);
    localparam int HALF = 20;
    localparam int LEAD = 5;

    initial begin
        bus_clock = 1'b1;
        data_pull_low = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Data moves well after the clock fall so no false start or stop is seen
    task automatic put_bit(input logic b);
        wait_cyc(LEAD);
        data_pull_low = !b;
        wait_cyc(HALF - LEAD);
        bus_clock = 1'b1;
        wait_cyc(HALF);
        bus_clock = 1'b0;
    endtask

    task automatic get_bit(output logic b);
        wait_cyc(LEAD);
        data_pull_low = 1'b0;
        wait_cyc(HALF - LEAD);
        bus_clock = 1'b1;
        wait_cyc(HALF / 2);
        b = bus_data;
        wait_cyc(HALF / 2);
        bus_clock = 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(b);
        ack = !b;
    endtask

    task automatic start_op;
        data_pull_low = 1'b1;
        wait_cyc(HALF);
        bus_clock = 1'b0;
    endtask

    task automatic stop_op;
        wait_cyc(LEAD);
        data_pull_low = 1'b1;
        wait_cyc(HALF - LEAD);
        bus_clock = 1'b1;
        wait_cyc(HALF);
        data_pull_low = 1'b0;
        wait_cyc(HALF);
    endtask

    // A count above two only probes the slave's tolerance of extra bytes
    task automatic write_op(input logic [6:0] dev, input int n, input logic [23:0] pl,
                            output logic ack);
        logic a;
        start_op();
        send_byte({dev, 1'b0}, ack);
        for (int k = 0; k < n; k++) send_byte(pl[23 - 8 * k -: 8], a);
        stop_op();
    endtask

    task automatic read_op(input logic [6:0] dev, output logic [7:0] d, output logic ack);
        start_op();
        send_byte({dev, 1'b1}, ack);
        d = 8'h00;
        if (ack) begin
            for (int i = 7; i >= 0; i--) get_bit(d[i]);
            put_bit(1'b1);
        end
        stop_op();
    endtask
endmodule

// *** dv/stm_regif_monitor.sv ***
/*
 Checker for the thermal monitor slave, watching top-level ports only.
 Assumes one core clock domain and a bind onto stm_regif.
*/
`timescale 1ns/100ps

module stm_regif_monitor #(
    parameter [31:0] FAST_PERIOD_CYCLES = 32'h0000_0040
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Bus pins
    input wire logic serial_clock_line,
    input wire logic serial_data_line_o,
    input wire logic serial_data_line_oe,
    // Conversion side
    input wire logic hw_standby_n,
    input wire logic conv_start,
    input wire logic meas_valid,
    input wire logic conv_busy,
    input wire logic [3:0] limit_flags
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    chk_pull_only: assert property (serial_data_line_oe |-> !serial_data_line_o)
        else $error("data line driven high");
    chk_ack_clock_low: assert property (
        $rose(serial_data_line_oe) |-> !serial_clock_line && !$past(serial_clock_line, 3))
        else $error("drive starts outside clock low");
    chk_data_clock_low: assert property (
        $changed(serial_data_line_oe) |-> !serial_clock_line)
        else $error("data drive moved while clock high");
    chk_start_single: assert property (conv_start |=> !conv_start [*8])
        else $error("conversion starts too close");
    chk_busy_on_start: assert property (conv_start |-> ##[0:1] conv_busy)
        else $error("busy missing after start");
    chk_busy_ends: assert property (meas_valid && conv_busy |-> ##[1:2] !conv_busy)
        else $error("busy held after result");
    chk_standby_blocks: assert property (!hw_standby_n [*6] |-> !conv_start)
        else $error("conversion while standby pin low");
    chk_flag_cause: assert property (
        (limit_flags & ~$past(limit_flags)) != 4'h0 |->
        $past(meas_valid, 1) || $past(meas_valid, 2) || $past(meas_valid, 3))
        else $error("limit flag set without result");
endmodule

bind stm_regif stm_regif_monitor #(.FAST_PERIOD_CYCLES(FAST_PERIOD_CYCLES)) u_stm_regif_monitor (
    .ref_clk(ref_clk), .resetn(resetn), .serial_clock_line(serial_clock_line),
    .serial_data_line_o(serial_data_line_o), .serial_data_line_oe(serial_data_line_oe),
    .hw_standby_n(hw_standby_n), .conv_start(conv_start), .meas_valid(meas_valid),
    .conv_busy(conv_busy), .limit_flags(limit_flags));

// *** dv/stm_regif_test.sv ***
/*
 Self-checking bench for the thermal monitor slave: registers, pointer,
 limit flags, one-shot, standby and address straps.
 Assumes stm_host_model as master and a front-end stand-in kept here.
*/
`timescale 1ns/100ps

module stm_regif_test;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] addr_strap_a = 2'h1;
    logic [1:0] addr_strap_b = 2'h2;
    logic hw_standby_n = 1'b1;
    logic meas_valid = 1'b0;
    logic [7:0] local_temp = 8'h19;
    logic [7:0] remote_temp = 8'h00;
    logic [6:0] dev = 7'h2B;
    logic [7:0] rd;
    logic ack;
    wire scl, host_low, dut_o, dut_oe, conv_start, conv_busy;
    wire [3:0] limit_flags;
    wire sda = !host_low && !(dut_oe && !dut_o);
    int mismatches = 0, samples_checked = 0, cycles = 0, starts = 0, results = 0;
    int fe_wait = 0, base, gap = 0, last_start = 0;
    // Busy lasts from start to the sampled result: stand-in delay plus one edge
    localparam int FE_LATENCY = 9;
    localparam int FAST = 64;
    logic [31:0] rows [9] = '{32'h0A05_0405, 32'h0B50_0550, 32'h0CF6_06F6, 32'h0D60_0760,
        32'h0E80_0880, 32'h0900_0300, 32'h0FAA_0F00, 32'h0A03_0A00, 32'h0A07_0407};
    logic [6:0] adds [9] = '{7'h18, 7'h19, 7'h1A, 7'h29, 7'h2A, 7'h2B, 7'h4C, 7'h4D, 7'h4E};

    stm_regif #(.FAST_PERIOD_CYCLES(FAST)) u_stm_regif (
        .ref_clk(ref_clk), .resetn(resetn), .serial_clock_line(scl),
        .serial_data_line_i(sda), .serial_data_line_o(dut_o), .serial_data_line_oe(dut_oe),
        .addr_strap_a(addr_strap_a), .addr_strap_b(addr_strap_b), .hw_standby_n(hw_standby_n),
        .conv_start(conv_start), .meas_valid(meas_valid), .local_temp(local_temp),
        .remote_temp(remote_temp), .conv_busy(conv_busy), .limit_flags(limit_flags));
    stm_host_model u_stm_host_model (.ref_clk(ref_clk), .bus_data(sda), .bus_clock(scl),
        .data_pull_low(host_low));

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // Front-end stand-in answers every start after a fixed delay
    always @(negedge ref_clk) begin
        cycles <= cycles + 1;
        if (conv_start === 1'b1) begin
            starts <= starts + 1;
            fe_wait <= 8;
            gap <= cycles - last_start;
            last_start <= cycles;
        end else if (fe_wait > 0) begin
            fe_wait <= fe_wait - 1;
        end
        meas_valid <= (fe_wait == 1);
        if (meas_valid) results <= results + 1;
        if (cycles == 80000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_count(input string what, input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic do_reset(input logic [1:0] sa, input logic [1:0] sb);
        addr_strap_a = sa;
        addr_strap_b = sb;
        resetn = 1'b0;
        repeat (6) @(negedge ref_clk);
        check_byte("reset outputs", 8'h00, {conv_start, conv_busy, dut_oe, dut_o, limit_flags});
        resetn = 1'b1;
        repeat (12) @(negedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
        u_stm_host_model.write_op(dev, 2, {ptr, val, 8'h00}, ack);
    endtask

    task automatic rd_at(input logic [7:0] ptr);
        u_stm_host_model.write_op(dev, 1, {ptr, 16'h0000}, ack);
        u_stm_host_model.read_op(dev, rd, ack);
    endtask

    task automatic wait_results(input int n);
        int target;
        target = results + n;
        for (int i = 0; i < 3000 && results < target; i++) @(negedge ref_clk);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        do_reset(2'h1, 2'h2);
        u_stm_host_model.read_op(dev, rd, ack);
        check_bit("own address ack", 1'b1, ack);
        check_byte("read at reset pointer", 8'h19, rd);
        for (int i = 0; i < 9; i++) begin
            wr(rows[i][31:24], rows[i][23:16]);
            rd_at(rows[i][15:8]);
            check_byte("table read", rows[i][7:0], rd);
        end
        u_stm_host_model.write_op(dev, 3, 24'h0B_1122, ack);
        u_stm_host_model.write_op(dev, 1, 24'h05_0000, ack);
        u_stm_host_model.read_op(dev, rd, ack);
        check_byte("extra byte ignored", 8'h11, rd);
        u_stm_host_model.read_op(7'h2A, rd, ack);
        check_bit("foreign address ack", 1'b0, ack);
        wr(8'h0B, 8'h19);
        wr(8'h0C, 8'hF6);
        wr(8'h0D, 8'h40);
        wr(8'h0E, 8'h00);
        rd_at(8'h02);
        wait_results(2);
        rd_at(8'h02);
        check_byte("status at limits", 8'h00, rd & 8'h78);
        local_temp = 8'h1A;
        remote_temp = 8'hFF;
        wait_results(2);
        check_byte("flags above and below", 8'h09, {4'h0, limit_flags});
        rd_at(8'h02);
        check_byte("status flags", 8'h48, rd & 8'h78);
        local_temp = 8'hF5;
        remote_temp = 8'h41;
        wait_results(2);
        rd_at(8'h02);
        wait_results(2);
        check_byte("negative limit flags", 8'h06, {4'h0, limit_flags});
        check_count("rate 7 period", FAST + FE_LATENCY, gap);
        wr(8'h0A, 8'h05);
        wait_results(3);
        check_count("rate 5 period", (FAST << 2) + FE_LATENCY, gap);
        local_temp = 8'h10;
        remote_temp = 8'h10;
        wr(8'h09, 8'h40);
        repeat (200) @(negedge ref_clk);
        base = starts;
        repeat (300) @(negedge ref_clk);
        check_bit("idle in standby", 1'b1, starts == base);
        wr(8'h0F, 8'h5A);
        repeat (200) @(negedge ref_clk);
        check_bit("one shot single start", 1'b1, starts == base + 1);
        check_bit("one shot back to standby", 1'b0, conv_busy);
        rd_at(8'h04);
        check_byte("rate kept", 8'h05, rd);
        hw_standby_n = 1'b0;
        base = starts;
        wr(8'h0F, 8'h5A);
        repeat (200) @(negedge ref_clk);
        check_bit("pin blocks one shot", 1'b1, starts == base);
        hw_standby_n = 1'b1;
        for (int i = 0; i < 9; i++) begin
            do_reset(2'(i / 3), 2'(i % 3));
            addr_strap_a = (i == 0) ? 2'h2 : 2'h0;
            addr_strap_b = addr_strap_a;
            dev = adds[i];
            u_stm_host_model.read_op(dev, rd, ack);
            check_bit("strap address ack", 1'b1, ack);
        end
        finish_test();
    end
endmodule

// *** hw/stm_regif.v ***
/*
 Serial bus slave and register file of the two-channel thermal monitor:
 bus decoding, pointer register, rate, configuration, limits, one-shot,
 conversion scheduling and limit flags.
 Assumes an open-drain data pin resolved outside, a bus clock from the master,
 and an analog front end that answers each conv_start with one meas_valid.
*/
`timescale 1ns/100ps
`include "stm_defs.vh"

module stm_regif #(
    parameter [31:0] FAST_PERIOD_CYCLES = `STM_FAST_CYCLES
) (
    // Clock and reset
    input wire ref_clk,
    input wire resetn,
    // Serial bus pins
    input wire serial_clock_line,
    input wire serial_data_line_i,
    output reg serial_data_line_o,
    output reg serial_data_line_oe,
    // Straps: 0 low, 1 open, 2 high; then the active-low standby pin
    input wire [1:0] addr_strap_a,
    input wire [1:0] addr_strap_b,
    input wire hw_standby_n,
    // Measurement front end
    output reg conv_start,
    input wire meas_valid,
    input wire [7:0] local_temp,
    input wire [7:0] remote_temp,
    // Status to the outside
    output reg conv_busy,
    output reg [3:0] limit_flags
);

    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_RECV = 7'h02;
    localparam [6:0] S_ACK = 7'h04;
    localparam [6:0] S_SEND = 7'h08;
    localparam [6:0] S_MACK = 7'h10;
    localparam [6:0] S_WAIT = 7'h20;
    localparam [6:0] S_ACKEND = 7'h40;

    function [6:0] strap_addr;
        input [1:0] a;
        input [1:0] b;
        reg [6:0] base;
        begin
            case (a)
                `STM_STRAP_LOW: base = 7'h18;
                `STM_STRAP_OPEN: base = 7'h29;
                default: base = 7'h4C;
            endcase
            case (b)
                `STM_STRAP_LOW: strap_addr = base;
                `STM_STRAP_OPEN: strap_addr = base + 7'h01;
                default: strap_addr = base + 7'h02;
            endcase
        end
    endfunction

    // Three-stage samplers on pins
    reg [2:0] scl_s, sda_s, sb_s;
    reg [1:0] sa1, sa2, sb1, sb2, sa3, sb3;
    reg scl_f, sda_f, scl_d, sda_d, sb_f;
    reg [2:0] strap_cnt;
    reg strap_done;
    reg [6:0] own_addr;

    // Protocol state
    reg [6:0] state;
    reg [7:0] shreg;
    reg [3:0] bitcnt;
    reg first_byte, addr_phase, is_read, matched;
    reg [1:0] wr_count;

    // Registers
    reg [7:0] pointer, cfg, rate, lhi, llo, rhi, rlo;
    reg [7:0] local_val, remote_val;
    reg [3:0] flags;
    reg oneshot_req, oneshot_run;
    reg [31:0] conv_cnt;
    reg clr_flags;

    wire scl_rise = scl_f & ~scl_d;
    wire scl_fall = ~scl_f & scl_d;
    wire start_c = scl_f & scl_d & sda_d & ~sda_f;
    wire stop_c = scl_f & scl_d & ~sda_d & sda_f;
    wire sw_standby = cfg[`STM_CFG_STANDBY];
    wire running = ~sw_standby & sb_f;

    always @(posedge ref_clk) begin
        scl_s <= {scl_s[1:0], serial_clock_line};
        sda_s <= {sda_s[1:0], serial_data_line_i};
        sb_s <= {sb_s[1:0], hw_standby_n};
        sa1 <= addr_strap_a;
        sa2 <= sa1;
        sa3 <= sa2;
        sb1 <= addr_strap_b;
        sb2 <= sb1;
        sb3 <= sb2;
        if (!resetn) begin
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            sb_f <= 1'b1;
        end else begin
            if (scl_s[1] == scl_s[2])
                scl_f <= scl_s[2];
            if (sda_s[1] == sda_s[2])
                sda_f <= sda_s[2];
            if (sb_s[1] == sb_s[2])
                sb_f <= sb_s[2];
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    // Strap capture once after reset; later pin changes are ignored
    always @(posedge ref_clk) begin
        if (!resetn) begin
            strap_cnt <= 3'h0;
            strap_done <= 1'b0;
            own_addr <= 7'h00;
        end else if (!strap_done) begin
            if (sa2 == sa3 && sb2 == sb3)
                strap_cnt <= strap_cnt + 3'h1;
            else
                strap_cnt <= 3'h0;
            if (strap_cnt == `STM_STRAP_SETTLE) begin
                strap_done <= 1'b1;
                own_addr <= strap_addr(sa3, sb3);
            end
        end
    end

    // Read data at the pointer; write-only pointers read as zero
    reg [7:0] rd_data;
    always @* begin
        case (pointer)
            `STM_RD_LOCAL: rd_data = local_val;
            `STM_RD_REMOTE: rd_data = remote_val;
            `STM_RD_STATUS: rd_data = {conv_busy, flags, 3'h0};
            `STM_RD_CONFIG: rd_data = cfg;
            `STM_RD_RATE: rd_data = rate;
            `STM_RD_LHI: rd_data = lhi;
            `STM_RD_LLO: rd_data = llo;
            `STM_RD_RHI: rd_data = rhi;
            `STM_RD_RLO: rd_data = rlo;
            default: rd_data = 8'h00;
        endcase
    end

    // Bus protocol engine
    always @(posedge ref_clk) begin
        oneshot_req <= 1'b0;
        clr_flags <= 1'b0;
        if (!resetn || !strap_done) begin
            state <= S_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            addr_phase <= 1'b0;
            is_read <= 1'b0;
            matched <= 1'b0;
            wr_count <= 2'h0;
            serial_data_line_o <= 1'b0;
            serial_data_line_oe <= 1'b0;
            pointer <= 8'h00;
            cfg <= `STM_RST_CONFIG;
            rate <= `STM_RST_RATE;
            lhi <= `STM_RST_HI;
            llo <= `STM_RST_LO;
            rhi <= `STM_RST_HI;
            rlo <= `STM_RST_LO;
            first_byte <= 1'b0;
        end else if (start_c) begin
            // Repeated start also lands here, so direction is fixed per operation
            state <= S_RECV;
            bitcnt <= 4'h0;
            addr_phase <= 1'b1;
            wr_count <= 2'h0;
            serial_data_line_oe <= 1'b0;
        end else if (stop_c) begin
            state <= S_IDLE;
            serial_data_line_oe <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    serial_data_line_oe <= 1'b0;
                end
                S_RECV: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_f};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'h8) begin
                        bitcnt <= 4'h0;
                        if (addr_phase) begin
                            addr_phase <= 1'b0;
                            if (shreg[7:1] == own_addr) begin
                                matched <= 1'b1;
                                is_read <= shreg[0];
                                serial_data_line_oe <= 1'b1;
                                state <= S_ACK;
                            end else begin
                                matched <= 1'b0;
                                state <= S_WAIT;
                            end
                        end else begin
                            serial_data_line_oe <= 1'b1;
                            state <= S_ACK;
                            if (wr_count == 2'h0) begin
                                pointer <= shreg;
                                wr_count <= 2'h1;
                            end else if (wr_count == 2'h1) begin
                                wr_count <= 2'h2;
                                case (pointer)
                                    `STM_WR_CONFIG: cfg <= shreg;
                                    `STM_WR_RATE: rate <= shreg;
                                    `STM_WR_LHI: lhi <= shreg;
                                    `STM_WR_LLO: llo <= shreg;
                                    `STM_WR_RHI: rhi <= shreg;
                                    `STM_WR_RLO: rlo <= shreg;
                                    // Data is dropped; the write alone fires it
                                    `STM_WR_ONESHOT: oneshot_req <= 1'b1;
                                    default: ;
                                endcase
                            end
                        end
                    end
                end
                S_ACK: begin
                    // Acknowledge held through the ninth clock high phase
                    if (scl_fall) begin
                        if (is_read) begin
                            shreg <= {rd_data[6:0], 1'b0};
                            serial_data_line_oe <= ~rd_data[7];
                            bitcnt <= 4'h1;
                            if (pointer == `STM_RD_STATUS)
                                clr_flags <= 1'b1;
                            state <= S_SEND;
                        end else begin
                            serial_data_line_oe <= 1'b0;
                            state <= S_RECV;
                        end
                    end
                end
                S_SEND: begin
                    if (scl_fall) begin
                        if (bitcnt == 4'h8) begin
                            serial_data_line_oe <= 1'b0;
                            state <= S_MACK;
                        end else begin
                            serial_data_line_oe <= ~shreg[7];
                            shreg <= {shreg[6:0], 1'b0};
                            bitcnt <= bitcnt + 4'h1;
                        end
                    end
                end
                S_MACK: begin
                    // No-acknowledge ends the read; acknowledge repeats the byte
                    if (scl_rise)
                        state <= sda_f ? S_WAIT : S_ACKEND;
                end
                S_ACKEND: begin
                    if (scl_fall) begin
                        shreg <= {rd_data[6:0], 1'b0};
                        serial_data_line_oe <= ~rd_data[7];
                        bitcnt <= 4'h1;
                        state <= S_SEND;
                    end
                end
                S_WAIT: begin
                    serial_data_line_oe <= 1'b0;
                end
                default: begin
                    state <= S_IDLE;
                    serial_data_line_oe <= 1'b0;
                end
            endcase
        end
    end

    // Conversion scheduling and limit flags
    always @(posedge ref_clk) begin
        conv_start <= 1'b0;
        if (!resetn) begin
            conv_cnt <= 32'h0000_0000;
            conv_busy <= 1'b0;
            oneshot_run <= 1'b0;
            local_val <= `STM_RST_TEMP;
            remote_val <= `STM_RST_TEMP;
            flags <= 4'h0;
            limit_flags <= 4'h0;
        end else begin
            if (!sb_f) begin
                // Pin low blocks all conversion and aborts one in flight
                conv_busy <= 1'b0;
                oneshot_run <= 1'b0;
                conv_cnt <= 32'h0000_0000;
            end else if (oneshot_req && sw_standby && !conv_busy) begin
                conv_start <= 1'b1;
                conv_busy <= 1'b1;
                oneshot_run <= 1'b1;
            end else if (conv_busy) begin
                if (!running && !oneshot_run)
                    conv_busy <= 1'b0;
                else if (meas_valid) begin
                    conv_busy <= 1'b0;
                    oneshot_run <= 1'b0;
                    local_val <= local_temp;
                    remote_val <= remote_temp;
                end
            end else if (running) begin
                if (conv_cnt == 32'h0000_0000) begin
                    // Slow codes stretch the fast period by a power of two
                    conv_cnt <= (FAST_PERIOD_CYCLES << (`STM_RATE_FAST
                        - rate[`STM_RATE_MSB:0])) - 32'h0000_0001;
                    conv_start <= 1'b1;
                    conv_busy <= 1'b1;
                end else
                    conv_cnt <= conv_cnt - 32'h0000_0001;
            end
            // New trips win over a clear in the same cycle
            flags <= (flags & {4{~clr_flags}}) | ({4{conv_busy & meas_valid & sb_f}} & {
                $signed(local_temp) > $signed(lhi),
                $signed(local_temp) < $signed(llo),
                $signed(remote_temp) > $signed(rhi),
                $signed(remote_temp) < $signed(rlo)});
            limit_flags <= flags;
        end
    end

endmodule

// *** inc/stm_defs.vh ***
/*
 Constants for the serial register interface of the two-channel thermal monitor:
 pointer values, reset values, strap codes and timing counts.
 Assumes a 50 MHz core clock and an including file that uses these macros only.
*/
// Overview of operation
// - Low three rate bits divide the conversion clock by 1 to 128, code 7 fastest.
// - Rate codes 0 to 7 give 0.0625 to 8 conversions per second.
// - Conversion rate register is writable and reads back its stored value.
// - High alarm on measurement strictly above limit, low alarm strictly below.
// - Negative limit values are accepted and honoured.
// - One-shot write in standby runs one conversion, then standby resumes.
// - The one-shot write itself triggers; its data byte is discarded.
// - Two three-level straps select one of nine 7-bit slave addresses.
// - Straps are latched once after reset and ignored afterwards.
// - First byte is 7-bit address MSB first plus direction bit.
// - Matching slave pulls data low for the ninth clock; others stay idle.
// - Direction 0 is master write, 1 is master read.
// - Bytes are nine clocks; data rising while clock high means stop.
// - One operation is all read or all write.
// - Writes carry one or two bytes; reads return one data byte. The code sends the same byte again each time the master acknowledges.
// - First written byte always loads the register pointer.
// - Second written byte is stored in the register the pointer selects.
// - Reads return the register at the current pointer, no pointer write needed.
// - Read and write pointer values differ per register.
// - One-shot sits at write pointer 0x0F and is not readable.
// - One-shot works with software standby and standby pin high; pin low blocks all.
// - Limit violations set the matching status flags.
`ifndef STM_DEFS_VH
`define STM_DEFS_VH
`define STM_RD_LOCAL 8'h00
`define STM_RD_REMOTE 8'h01
`define STM_RD_STATUS 8'h02
`define STM_RD_CONFIG 8'h03
`define STM_RD_RATE 8'h04
`define STM_RD_LHI 8'h05
`define STM_RD_LLO 8'h06
`define STM_RD_RHI 8'h07
`define STM_RD_RLO 8'h08
`define STM_WR_CONFIG 8'h09
`define STM_WR_RATE 8'h0A
`define STM_WR_LHI 8'h0B
`define STM_WR_LLO 8'h0C
`define STM_WR_RHI 8'h0D
`define STM_WR_RLO 8'h0E
`define STM_WR_ONESHOT 8'h0F
`define STM_RST_CONFIG 8'h00
`define STM_RST_RATE 8'h02
`define STM_RST_HI 8'h7F
`define STM_RST_LO 8'hC9
`define STM_RST_TEMP 8'h80
`define STM_CFG_STANDBY 6
`define STM_RATE_MSB 2
`define STM_RATE_FAST 3'h7
`define STM_ST_BUSY 7
`define STM_ST_LHI 6
`define STM_ST_LLO 5
`define STM_ST_RHI 4
`define STM_ST_RLO 3
`define STM_STRAP_LOW 2'h0
`define STM_STRAP_OPEN 2'h1
`define STM_STRAP_HIGH 2'h2
`define STM_STRAP_SETTLE 3'h4
`define STM_CLK_KHZ 50000
`define STM_FAST_MS 125
`define STM_FAST_CYCLES (`STM_FAST_MS * `STM_CLK_KHZ)
`endif
